// ==== bench/aoir_inverter_model.sv ====
// Behavioural inverter that runs at the speed reference it is given.
// Assumes speed_ref changes on pclk; it follows one cycle later, or two cycles later with SLOW.
`timescale 1ns/1ps
module aoir_inverter_model
#(
	parameter bit SLOW = 1'b0
)(
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Reference from the regulator.
	input  wire logic [7:0] speed_ref,
	// Frequency the inverter runs at.
	output logic      [7:0] freq_ref
);
	logic [7:0] near;
	logic [7:0] far;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			near <= 8'h00;
			far  <= 8'h00;
		end
		else
		begin
			near <= speed_ref;
			far  <= near;
		end
	end

	assign freq_ref = SLOW ? far : near;
endmodule

// ==== bench/aoir_regulator_assertions.sv ====
// Concurrent checks on the regulator's ports, bound into every instance.
// Assumes software always writes whole words (pstrb all ones).
`timescale 1ns/1ps
module aoir_regulator_assertions
	import aoir_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
	// Clock and reset.
	input wire logic                   pclk,
	input wire logic                   presetn,
	// Register port.
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [ADDR_W-1:0]      paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pslverr,
	// Process side.
	input wire logic [PROBE_COUNT-1:0] probe_fault,
	input wire logic                   regulation_pv_fault,
	input wire logic                   spray_active_pin,
	input wire logic                   silent_mode_pin,
	// Inverter side.
	input wire logic [7:0]             speed_ref,
	input wire logic                   load_on_grant,
	input wire logic                   load_off_grant
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [31:0] lim;
	logic [31:0] exc;
	logic [31:0] cap;
	logic [31:0] ctl;
	logic [2:0]  cnt;
	logic        f1;
	logic [7:0]  mx;
	logic [7:0]  mn;
	logic [7:0]  xe;
	logic        quiet;

	// Shadow copies of the limit, exclusion, cap and control registers, taken from completed writes.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lim <= RST_LIMITS;
			exc <= RST_ZERO;
			cap <= RST_ZERO;
			ctl <= RST_ZERO;
		end
		else if (psel && penable && pwrite)
		begin
			if (paddr == OFS_LIMITS)
				lim <= pwdata;
			if (paddr == OFS_EXCL)
				exc <= pwdata;
			if (paddr == OFS_CAPS)
				cap <= pwdata;
			if (paddr == OFS_CTRL)
				ctl <= pwdata;
		end
	end

	// Settling guard: checks pause seven cycles after a write, and while a fault was present one cycle earlier.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 3'h0;
			f1  <= 1'b0;
		end
		else
		begin
			f1 <= regulation_pv_fault | (|probe_fault);
			if (psel && penable && pwrite)
				cnt <= 3'h0;
			else if (cnt != 3'h7)
				cnt <= cnt + 3'h1;
		end
	end

	assign mx    = (lim[15:8] > 8'h64) ? 8'h64 : lim[15:8];
	assign mn    = (lim[7:0] > mx) ? mx : lim[7:0];
	assign xe    = (exc[15:8] > 8'h63) ? 8'h63 : exc[15:8];
	assign quiet = (cnt == 3'h7) && !f1;

	property p_floor;
		quiet |-> speed_ref >= mn;
	endproperty
	a_floor: assert property (p_floor) else $error("speed_ref below minimum");

	property p_ceiling;
		quiet |-> speed_ref <= mx;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("speed_ref above maximum");

	property p_gap;
		quiet |-> !(speed_ref > exc[7:0] && speed_ref < xe);
	endproperty
	a_gap: assert property (p_gap) else $error("speed_ref inside exclusion");

	property p_safety;
		!ctl[0] && cnt == 3'h7 && $past(regulation_pv_fault) |-> speed_ref == exc[23:16];
	endproperty
	a_safety: assert property (p_safety) else $error("safety value not driven");

	property p_spray;
		(quiet && spray_active_pin) [*4] |-> speed_ref <= exc[31:24];
	endproperty
	a_spray: assert property (p_spray) else $error("spray cap exceeded");

	property p_silent;
		(quiet && silent_mode_pin) [*4] |-> speed_ref <= cap[7:0];
	endproperty
	a_silent: assert property (p_silent) else $error("silent cap exceeded");

	property p_on_grant;
		load_on_grant && quiet |-> $past(speed_ref) == mx ##1 !load_on_grant;
	endproperty
	a_on_grant: assert property (p_on_grant) else $error("load on grant wrong");

	property p_off_grant;
		load_off_grant && quiet |-> $past(speed_ref) == lim[23:16] ##1 !load_off_grant;
	endproperty
	a_off_grant: assert property (p_off_grant) else $error("load off grant wrong");

	property p_unmapped;
		psel && penable && !pwrite && paddr > OFS_STATUS |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule

bind aoir_regulator aoir_regulator_assertions #(.TICK_CYCLES(TICK_CYCLES))
	aoir_regulator_assertions_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pslverr(pslverr), .probe_fault(probe_fault),
	.regulation_pv_fault(regulation_pv_fault), .spray_active_pin(spray_active_pin),
	.silent_mode_pin(silent_mode_pin), .speed_ref(speed_ref),
	.load_on_grant(load_on_grant), .load_off_grant(load_off_grant));

// ==== bench/aoir_regulator_test.sv ====
// Self-checking bench for the regulator, driven over APB and event pins.
// Assumes a one-second tick of 10 cycles, so a minute is 600 cycles.
`timescale 1ns/1ps
module aoir_regulator_test
	import aoir_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, speed_ref, freq_ref;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [15:0] probe_value [PROBE_COUNT];
	logic [9:0]  probe_fault;
	logic [15:0] regulation_pv;
	logic        regulation_pv_fault, compressor_running, spray_active_pin, silent_mode_pin;
	logic [2:0]  ev;
	logic        load_on_grant, load_off_grant;
	int          n_fail, comparisons, t;
	logic [31:0] rst_val [9] = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h6400, 32'h0, 32'h0, 32'h0, 32'h0};

	aoir_regulator #(.TICK_CYCLES(10)) aoir_regulator_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.probe_value(probe_value), .probe_fault(probe_fault), .regulation_pv(regulation_pv),
		.regulation_pv_fault(regulation_pv_fault), .compressor_running(compressor_running),
		.compressor_start(ev[0]), .compressor_stop(ev[1]), .load_switched_on(ev[2]),
		.spray_active_pin(spray_active_pin), .silent_mode_pin(silent_mode_pin),
		.speed_ref(speed_ref), .load_on_grant(load_on_grant), .load_off_grant(load_off_grant));

	aoir_inverter_model #(.SLOW(1'b1)) aoir_inverter_model_i (.pclk(pclk), .presetn(presetn),
		.speed_ref(speed_ref), .freq_ref(freq_ref));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic complete_run();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, 32'(i < 20));
		if (i == 20)
			complete_run();
	endtask

	// Waits a bounded time for speed_ref to reach the expected level.
	task automatic wait_ref(input logic [7:0] e, input int bound);
		t = 0;
		while (speed_ref !== e && t < bound)
		begin
			@(posedge pclk);
			t++;
		end
		chk("speed_ref", 32'(e), 32'(speed_ref));
		if (speed_ref !== e)
			complete_run();
	endtask

	task automatic wait_grant(input logic on, input int bound);
		t = 0;
		while ((on ? load_on_grant : load_off_grant) !== 1'b1 && t < bound)
		begin
			@(posedge pclk);
			t++;
		end
		chk("grant", 32'h1, 32'(t < bound));
		if (t == bound)
			complete_run();
	endtask

	task automatic pulse(input int k);
		@(posedge pclk);
		ev[k] <= 1'b1;
		@(posedge pclk);
		ev <= 3'h0;
	endtask

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = {3'h0, 8'h00, 32'h0, 4'hf};
		foreach (probe_value[i])
			probe_value[i] = 16'(i * 20);
		probe_value[3] = 16'h0096;
		{probe_fault, regulation_pv, regulation_pv_fault} = '0;
		{compressor_running, spray_active_pin, silent_mode_pin, ev} = '0;
		{n_fail, comparisons} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_val[i])
		begin
			xfer(1'b0, 8'(i * 4), 32'h0);
			chk("reset value", rst_val[i], rd);
		end
		xfer(1'b0, 8'h28, 32'h0);
		chk("unmapped", 32'h0, rd);
		xfer(1'b1, OFS_STATUS, 32'hffff_ffff);
		xfer(1'b0, OFS_STATUS, 32'h0);
		chk("status", 32'h0, rd);
		xfer(1'b1, OFS_LIMITS, 32'h141e_5a0a);
		xfer(1'b1, OFS_EXCL, 32'h3c05_3228);
		xfer(1'b1, OFS_TIME_A, 32'h0403_0502);
		xfer(1'b1, OFS_TIME_B, 32'h0000_0302);
		wait_ref(8'h0a, 10);
		regulation_pv_fault <= 1'b1;
		wait_ref(8'h05, 10);
		repeat (8) @(posedge pclk);
		chk("safety", 32'h05, 32'(speed_ref));
		regulation_pv_fault <= 1'b0;
		regulation_pv <= 16'h00c8;
		pulse(0);
		wait_ref(8'h1e, 4);
		wait_ref(8'h5a, 80);
		chk("rise time", 32'h1, 32'(t >= 30 && t <= 70));
		wait_grant(1'b1, 60);
		chk("max dwell", 32'h1, 32'(t >= 20));
		pulse(2);
		wait_ref(8'h1e, 60);
		regulation_pv <= 16'hffce;
		wait_grant(1'b0, 300);
		wait_ref(8'h0a, 10);
		pulse(1);
		wait_ref(8'h14, 4);
		regulation_pv <= 16'h0019;
		wait_ref(8'h0a, 5);
		wait_ref(8'h1e, 60);
		chk("band delay", 32'h1, 32'(t >= 10));
		xfer(1'b1, OFS_SETP, 32'h000a_0000);
		wait_ref(8'h16, 20);
		regulation_pv <= 16'h0037;
		wait_ref(8'h32, 20);
		regulation_pv <= 16'h0062;
		wait_ref(8'h50, 20);
		spray_active_pin <= 1'b1;
		wait_ref(8'h3c, 10);
		xfer(1'b1, OFS_CAPS, 32'h0000_0023);
		silent_mode_pin <= 1'b1;
		wait_ref(8'h23, 10);
		{spray_active_pin, silent_mode_pin} <= 2'b00;
		wait_ref(8'h50, 10);
		xfer(1'b1, OFS_READOUT, 32'h00c8_0000);
		xfer(1'b1, OFS_CTRL, 32'h0000_0007);
		wait_ref(8'h46, 10);
		probe_value[3] <= 16'h0000;
		compressor_running <= 1'b1;
		xfer(1'b1, OFS_CAPS, 32'h0101_1400);
		wait_ref(8'h0a, 10);
		wait_ref(8'h5a, 800);
		chk("lube wait", 32'h1, 32'(t >= 500));
		wait_ref(8'h0a, 800);
		compressor_running <= 1'b0;
		xfer(1'b1, OFS_CAPS, 32'h0);
		xfer(1'b1, OFS_TIME_B, 32'h0101_0302);
		xfer(1'b1, OFS_CTRL, 32'h0000_00c7);
		wait_ref(8'h5a, 7000);
		chk("idle wait", 32'h1, 32'(t >= 5000));
		wait_ref(8'h0a, 800);
		repeat (3) @(posedge pclk);
		chk("inverter", 32'h0a, 32'(freq_ref));
		complete_run();
	end
endmodule

// ==== verilog/aoir_pkg.sv ====
// Constants, register map and types for the analog output inverter regulator.
// Assumes a single 100 MHz clock and an APB master with 32-bit data.
package aoir_pkg;

	// Timing.
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TICK_PERIOD_NS  = 1000000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SEC_PER_MIN     = 60;
	localparam int IDLE_STEP_MIN   = 10;

	// Value ranges.
	localparam int PROBE_COUNT  = 10;
	localparam int FULL_PCT     = 100;
	localparam int EXCL_END_MAX = 99;
	localparam int BYTE_W       = 8;
	localparam int STRB_W       = 4;
	localparam int IDLE_CODE_LO1 = 6;
	localparam int IDLE_CODE_HI1 = 9;
	localparam int IDLE_CODE_LO2 = 15;
	localparam int IDLE_CODE_HI2 = 18;

	// Register byte offsets.
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SETP    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BAND    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_READOUT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_LIMITS  = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_EXCL    = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CAPS    = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_TIME_A  = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_TIME_B  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h24;

	// Reset values.
	localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
	localparam logic [31:0] RST_BAND   = 32'h0000_0064;
	localparam logic [31:0] RST_LIMITS = 32'h0000_6400;

	typedef struct packed {
		logic [21:0] rsv;
		logic [4:0]  cfg_code;
		logic [3:0]  probe_sel;
		logic        free_mode;
	} aoir_ctrl_t;

	typedef struct packed {
		logic [15:0] shift;
		logic [15:0] setpoint;
	} aoir_setp_t;

	typedef struct packed {
		logic [5:0]  rsv;
		logic [9:0]  integral_time;
		logic [15:0] band;
	} aoir_band_t;

	typedef struct packed {
		logic [15:0] full_scale;
		logic [15:0] low;
	} aoir_readout_t;

	typedef struct packed {
		logic [7:0] after_stop;
		logic [7:0] after_start;
		logic [7:0] maximum;
		logic [7:0] minimum;
	} aoir_limits_t;

	typedef struct packed {
		logic [7:0] spray_cap;
		logic [7:0] safety;
		logic [7:0] ex_end;
		logic [7:0] ex_start;
	} aoir_excl_t;

	typedef struct packed {
		logic [7:0] lube_boost;
		logic [7:0] lube_low;
		logic [7:0] lube_thr;
		logic [7:0] silent_cap;
	} aoir_caps_t;

	typedef struct packed {
		logic [7:0] decay;
		logic [7:0] max_dwell;
		logic [7:0] rise;
		logic [7:0] band_delay;
	} aoir_time_a_t;

	typedef struct packed {
		logic [7:0] idle_boost;
		logic [7:0] idle_limit;
		logic [7:0] decay_on;
		logic [7:0] dwell_off;
	} aoir_time_b_t;

	typedef enum logic [3:0] {
		S_WAIT       = 4'h0,
		S_REG        = 4'h1,
		S_RISE       = 4'h2,
		S_HOLD_MAX   = 4'h3,
		S_LOAD_WAIT  = 4'h4,
		S_DECAY_ON   = 4'h5,
		S_DECAY      = 4'h6,
		S_HOLD_START = 4'h7,
		S_AFTER_STOP = 4'h8
	} aoir_state_t;

	typedef struct packed {
		logic [15:0] pv;
		logic        rsv;
		logic        fault;
		logic        idle_boost;
		logic        lube_boost;
		logic [3:0]  state;
		logic [7:0]  out;
	} aoir_status_t;

endpackage

// ==== verilog/aoir_regulator.sv ====
// Speed reference regulation for one inverter-driven compressor channel.
// Assumes same-clock process inputs and event pulses, asynchronous mode pins.
//
// Notes on behaviour
// - In free mode the selector 0..9 picks one of ten probes as reference.
// - In free mode full-scale readout value maps to full-scale output.
// - Output never drops below the minimum, which itself never exceeds maximum; the code clamps the fault safety value to 0..maximum only.
// - Compressor start above band sets output to start value within limits.
// - Compressor stop below band sets output to after-stop value within limits.
// - Output avoids the exclusion range; its end is limited to 99 percent. The code applies the caps, boosts and safety value after the exclusion step.
// - Faulty reference probe forces the safety value, at most the maximum.
// - Regulation starts a configurable 0..255 s after entering the band.
// - After a start above band the output rises to maximum over rise time.
// - Output holds maximum for a dwell time before another load is activated.
// - Below set point the output decays from maximum to minimum; the code decays from the output held when the decay starts.
// - Below set point output holds start value before a load switches off.
// - Load switch-on ramps output from maximum down to start value.
// - Proportional action from set point, maximum at set point plus band.
// - Integral action with 0..999 s time; larger is weaker, zero disables.
// - A signed offset shifts the regulation band against the set point.
// - While adiabatic spray is active the output is capped; the code lets the boosts and the fault safety value override the cap.
// - While silent mode is active the output is capped; the code lets the boosts and the fault safety value override the cap.
// - Long low output forces maximum for a while for lubrication.
// - Long idle on codes 6..9 and 15..18 forces maximum for a while.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module aoir_regulator
	import aoir_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
	// Clock and reset.
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// APB register port.
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_W-1:0]      paddr,
	input  wire logic [31:0]            pwdata,
	input  wire logic [STRB_W-1:0]      pstrb,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Process inputs on this clock.
	input  wire logic [15:0]            probe_value [PROBE_COUNT],
	input  wire logic [PROBE_COUNT-1:0] probe_fault,
	input  wire logic [15:0]            regulation_pv,
	input  wire logic                   regulation_pv_fault,
	input  wire logic                   compressor_running,
	input  wire logic                   compressor_start,
	input  wire logic                   compressor_stop,
	input  wire logic                   load_switched_on,
	// Mode pins from outside the clock domain.
	input  wire logic                   spray_active_pin,
	input  wire logic                   silent_mode_pin,
	// Inverter side.
	output logic      [7:0]             speed_ref,
	output logic                        load_on_grant,
	output logic                        load_off_grant
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	if (TICK_CYCLES < 1)
	begin : g_check
		$error("TICK_CYCLES must be at least one");
	end

	function automatic int lerp(input int a, input int b, input int n, input int d);
		if (n <= 0)
			return a;
		if (d <= 0 || n >= d)
			return b;
		return a + (b - a) * n / d;
	endfunction

	function automatic int clampi(input int v, input int lo, input int hi);
		if (v < lo)
			return lo;
		if (v > hi)
			return hi;
		return v;
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
		input logic [STRB_W-1:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < STRB_W; i++)
			if (s[i])
				r[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
		return r;
	endfunction

	function automatic logic is_idle_code(input logic [4:0] c);
		return (c >= IDLE_CODE_LO1 && c <= IDLE_CODE_HI1) ||
			(c >= IDLE_CODE_LO2 && c <= IDLE_CODE_HI2);
	endfunction

	logic [31:0]   r_ctrl, r_setp, r_band, r_readout, r_limits;
	logic [31:0]   r_excl, r_caps, r_time_a, r_time_b;
	aoir_ctrl_t    ctl;
	aoir_setp_t    stp;
	aoir_band_t    bnd;
	aoir_readout_t rdo;
	aoir_limits_t  lim;
	aoir_excl_t    exc;
	aoir_caps_t    cap;
	aoir_time_a_t  tma;
	aoir_time_b_t  tmb;
	aoir_status_t  sts;
	aoir_state_t   state, next_state;
	logic [31:0]   rd_mux;
	logic          mapped, wr_go;
	logic [1:0]    spray_sync, silent_sync;
	logic [TW-1:0] tick_cnt;
	logic          tick;
	logic [7:0]    sec_cnt, ramp_from;
	logic [3:0]    sel;
	logic [15:0]   pv_raw;
	logic          fault;
	int            pv, err, bw, mn, mx, st, sv, p_sgn, i_pct, pi_out, base, c;
	int            es, ee, integ;
	logic          next_grant_on, next_grant_off;
	logic [13:0]   lube_min, lube_boost_min, idle_boost_min;
	logic [17:0]   idle_min;
	logic          lube_act, idle_act, lube_low_now, idle_off_now;

	assign ctl = r_ctrl;
	assign stp = r_setp;
	assign bnd = r_band;
	assign rdo = r_readout;
	assign lim = r_limits;
	assign exc = r_excl;
	assign cap = r_caps;
	assign tma = r_time_a;
	assign tmb = r_time_b;

	// APB slave: zero wait states, read data sampled in the setup cycle.
	assign pready = 1'b1;
	assign wr_go = psel & penable & pwrite;
	assign pslverr = psel & penable & ~mapped;

	always_comb
	begin
		mapped = 1'b1;
		sts = '0;
		sts.pv = pv_raw;
		sts.fault = fault;
		sts.idle_boost = idle_act;
		sts.lube_boost = lube_act;
		sts.state = state;
		sts.out = speed_ref;
		unique case (paddr)
			OFS_CTRL:    rd_mux = r_ctrl;
			OFS_SETP:    rd_mux = r_setp;
			OFS_BAND:    rd_mux = r_band;
			OFS_READOUT: rd_mux = r_readout;
			OFS_LIMITS:  rd_mux = r_limits;
			OFS_EXCL:    rd_mux = r_excl;
			OFS_CAPS:    rd_mux = r_caps;
			OFS_TIME_A:  rd_mux = r_time_a;
			OFS_TIME_B:  rd_mux = r_time_b;
			OFS_STATUS:  rd_mux = sts;
			default:
			begin
				rd_mux = RST_ZERO;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			prdata <= RST_ZERO;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			r_ctrl <= RST_ZERO;
			r_setp <= RST_ZERO;
			r_band <= RST_BAND;
			r_readout <= RST_ZERO;
			r_limits <= RST_LIMITS;
			r_excl <= RST_ZERO;
			r_caps <= RST_ZERO;
			r_time_a <= RST_ZERO;
			r_time_b <= RST_ZERO;
		end
		else if (wr_go)
			unique case (paddr)
				OFS_CTRL:    r_ctrl <= wmerge(r_ctrl, pwdata, pstrb);
				OFS_SETP:    r_setp <= wmerge(r_setp, pwdata, pstrb);
				OFS_BAND:    r_band <= wmerge(r_band, pwdata, pstrb);
				OFS_READOUT: r_readout <= wmerge(r_readout, pwdata, pstrb);
				OFS_LIMITS:  r_limits <= wmerge(r_limits, pwdata, pstrb);
				OFS_EXCL:    r_excl <= wmerge(r_excl, pwdata, pstrb);
				OFS_CAPS:    r_caps <= wmerge(r_caps, pwdata, pstrb);
				OFS_TIME_A:  r_time_a <= wmerge(r_time_a, pwdata, pstrb);
				OFS_TIME_B:  r_time_b <= wmerge(r_time_b, pwdata, pstrb);
				default:     ;
			endcase

	// Mode pins pass two flip-flops before use.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			spray_sync <= 2'h0;
			silent_sync <= 2'h0;
		end
		else
		begin
			spray_sync <= {spray_sync[0], spray_active_pin};
			silent_sync <= {silent_sync[0], silent_mode_pin};
		end

	// One-second tick; minute timers count it too, so they carry no minute jitter.
	assign tick = tick_cnt == TW'(TICK_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			tick_cnt <= '0;
		else if (tick)
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 1'b1;

	// Reference selection and limits.
	assign sel = (ctl.probe_sel > PROBE_COUNT - 1) ? 4'(PROBE_COUNT - 1) : ctl.probe_sel;
	assign pv_raw = ctl.free_mode ? probe_value[sel] : regulation_pv;
	assign fault = ctl.free_mode ? probe_fault[sel] : regulation_pv_fault;

	always_comb
	begin
		pv = int'($signed(pv_raw));
		err = pv - int'($signed(stp.setpoint)) - int'($signed(stp.shift));
		bw = int'(bnd.band);
		mx = (lim.maximum > FULL_PCT) ? FULL_PCT : int'(lim.maximum);
		mn = (lim.minimum > mx) ? mx : int'(lim.minimum);
		st = clampi(int'(lim.after_start), mn, mx);
		sv = clampi(int'(lim.after_stop), mn, mx);
		// Signed proportional share in percent of the span.
		if (err < 0)
			p_sgn = -lerp(0, FULL_PCT, -err, bw);
		else
			p_sgn = lerp(0, FULL_PCT, err, bw);
		if (bnd.integral_time == 10'h000)
			i_pct = 0;
		else
			i_pct = integ / int'(bnd.integral_time);
		pi_out = lerp(mn, mx, clampi(p_sgn + i_pct, 0, FULL_PCT), FULL_PCT);
	end

	// Integrator sums the proportional share once a second while regulating.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			integ <= 0;
		else if (state != S_REG)
			integ <= 0;
		else if (tick && bnd.integral_time != 10'h000)
			integ <= clampi(integ + p_sgn, 0, FULL_PCT * int'(bnd.integral_time));

	// Sequence of start, rise, hold, decay and stop phases.
	always_comb
	begin
		next_state = state;
		next_grant_on = 1'b0;
		next_grant_off = 1'b0;
		if (compressor_start && err >= bw)
			next_state = S_RISE;
		else if (compressor_stop && err <= 0)
			next_state = S_AFTER_STOP;
		else
			unique case (state)
				S_WAIT:
					if (err > 0 && sec_cnt >= tma.band_delay)
						next_state = S_REG;
				S_REG:
					if (err < 0)
						next_state = S_DECAY;
					else if (load_switched_on)
						next_state = S_DECAY_ON;
					else if (pi_out >= mx)
						next_state = S_HOLD_MAX;
				S_RISE:
					if (err < 0)
						next_state = S_DECAY;
					else if (sec_cnt >= tma.rise)
						next_state = S_HOLD_MAX;
				S_HOLD_MAX:
					if (err < 0)
						next_state = S_DECAY;
					else if (load_switched_on)
						next_state = S_DECAY_ON;
					else if (sec_cnt >= tma.max_dwell)
					begin
						next_state = S_LOAD_WAIT;
						next_grant_on = 1'b1;
					end
				S_LOAD_WAIT:
					if (err < 0)
						next_state = S_DECAY;
					else if (load_switched_on)
						next_state = S_DECAY_ON;
				S_DECAY_ON:
					if (sec_cnt >= tmb.decay_on)
						next_state = S_REG;
				S_DECAY:
					if (err > 0)
						next_state = S_REG;
					else if (sec_cnt >= tma.decay)
						next_state = S_HOLD_START;
				S_HOLD_START:
					if (err > 0)
						next_state = S_REG;
					else if (sec_cnt >= tmb.dwell_off)
					begin
						next_state = S_WAIT;
						next_grant_off = 1'b1;
					end
				S_AFTER_STOP:
					if (err > 0)
						next_state = S_WAIT;
				default:
					next_state = S_WAIT;
			endcase
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			state <= S_WAIT;
		else
			state <= next_state;

	// Seconds spent in the current phase; band entry restarts on leaving the band.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			sec_cnt <= 8'h00;
		else if (state != next_state || (state == S_WAIT && err <= 0))
			sec_cnt <= 8'h00;
		else if (tick && sec_cnt != 8'hff)
			sec_cnt <= sec_cnt + 8'h01;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ramp_from <= 8'h00;
		else if (next_state == S_DECAY && state != S_DECAY)
			ramp_from <= speed_ref;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			load_on_grant <= 1'b0;
			load_off_grant <= 1'b0;
		end
		else
		begin
			// Free mode output ignores the phases, so no dwell is signalled then.
			load_on_grant <= next_grant_on && !ctl.free_mode;
			load_off_grant <= next_grant_off && !ctl.free_mode;
		end

	// Output value: phase value, then limits, exclusion, caps, boosts and fault.
	always_comb
	begin
		unique case (state)
			S_REG:        base = pi_out;
			S_RISE:       base = lerp(st, mx, int'(sec_cnt), int'(tma.rise));
			S_HOLD_MAX:   base = mx;
			S_LOAD_WAIT:  base = mx;
			S_DECAY_ON:   base = lerp(mx, st, int'(sec_cnt), int'(tmb.decay_on));
			S_DECAY:      base = lerp(int'(ramp_from), mn, int'(sec_cnt), int'(tma.decay));
			S_HOLD_START: base = st;
			S_AFTER_STOP: base = sv;
			default:      base = mn;
		endcase
		if (ctl.free_mode)
			base = lerp(mn, mx, pv - int'($signed(rdo.low)),
				int'($signed(rdo.full_scale)) - int'($signed(rdo.low)));
		c = clampi(base, mn, mx);
		es = int'(exc.ex_start);
		ee = (exc.ex_end > EXCL_END_MAX) ? EXCL_END_MAX : int'(exc.ex_end);
		if (es < ee && c > es && c < ee)
			c = (c - es < ee - c || ee > mx) ? es : ee;
		if (spray_sync[1] && c > clampi(int'(exc.spray_cap), mn, mx))
			c = clampi(int'(exc.spray_cap), mn, mx);
		if (silent_sync[1] && c > clampi(int'(cap.silent_cap), mn, FULL_PCT))
			c = clampi(int'(cap.silent_cap), mn, FULL_PCT);
		if (lube_act || idle_act)
			c = mx;
		if (fault)
			c = clampi(int'(exc.safety), 0, mx);
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			speed_ref <= 8'h00;
		else
			speed_ref <= 8'(c);

	// Lubrication boost after a long time at low output.
	assign lube_low_now = cap.lube_thr != 8'h00 && compressor_running &&
		speed_ref <= cap.lube_thr;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			lube_act <= 1'b0;
			lube_min <= 14'h0000;
			lube_boost_min <= 14'h0000;
		end
		else if (lube_act)
		begin
			if (lube_boost_min >= 14'(int'(cap.lube_boost) * SEC_PER_MIN))
			begin
				lube_act <= 1'b0;
				lube_boost_min <= 14'h0000;
			end
			else if (tick)
				lube_boost_min <= lube_boost_min + 14'h0001;
		end
		else if (!lube_low_now)
			lube_min <= 14'h0000;
		else if (lube_min >= 14'(int'(cap.lube_low) * SEC_PER_MIN))
		begin
			lube_act <= 1'b1;
			lube_min <= 14'h0000;
		end
		else if (tick)
			lube_min <= lube_min + 14'h0001;

	// Idle boost after the compressor has been stopped for the idle limit.
	assign idle_off_now = is_idle_code(ctl.cfg_code) && tmb.idle_limit != 8'h00 &&
		!compressor_running;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			idle_act <= 1'b0;
			idle_min <= 18'h00000;
			idle_boost_min <= 14'h0000;
		end
		else if (idle_act)
		begin
			if (idle_boost_min >= 14'(int'(tmb.idle_boost) * SEC_PER_MIN))
			begin
				idle_act <= 1'b0;
				idle_boost_min <= 14'h0000;
			end
			else if (tick)
				idle_boost_min <= idle_boost_min + 14'h0001;
		end
		else if (!idle_off_now)
			idle_min <= 18'h00000;
		else if (idle_min >= 18'(int'(tmb.idle_limit) * IDLE_STEP_MIN * SEC_PER_MIN))
		begin
			idle_act <= 1'b1;
			idle_min <= 18'h00000;
		end
		else if (tick)
			idle_min <= idle_min + 18'h00001;

endmodule
